// ==== shared/omcg_cfg.svh ====
`ifndef OMCG_CFG_SVH
`define OMCG_CFG_SVH

// Oscillator pin positions
`define OMCG_FAST_XT      0
`define OMCG_FAST_RC      1
`define OMCG_SLOW_XT      2
`define OMCG_SLOW_RC      3

// Divider select field
`define OMCG_DIV_SUB_MAX  3'h1
`define OMCG_DIV_BASE     3'h2
`define OMCG_DIV_MASK     6'h3F

// Reset selection: undivided fast clock
`define OMCG_SEL_RESET    4'h8

// Fast-clock edges run on the substitute clock after a fast wake-up
`define OMCG_WARM_LAST    8'h7F

// Cycles after reset release before strap_q is loaded
`define OMCG_STRAP_WAIT   2'h2

`endif

// ==== shared/omcg_pkg.sv ====
package omcg_pkg;

  // Operating modes
  typedef enum logic [2:0] {
    omcg_normal,
    omcg_slow,
    idle_clock_stopped_state,
    idle_clock_running_state,
    deep_halt_state,
    light_halt_state
  } omcg_mode_t;

  // Control bits from the CPU core
  typedef struct packed {
    logic       high_low_clock_select;
    logic [2:0] sysclk_divider_select;
    logic       halt_to_idle_enable;
    logic       idle_sysclk_keep_on;
    logic       low_voltage_detect_enable;
    logic       fast_wakeup_enable;
  } omcg_ctrl_t;

  // Configuration options, one bit per source choice
  typedef struct packed {
    logic hf_from_rc;
    logic sub_from_rc;
    logic tbc_from_rc;
  } omcg_strap_t;

  // Active system clock selection
  typedef struct packed {
    logic       hl;
    logic [2:0] div;
  } omcg_sel_t;

endpackage : omcg_pkg

// ==== design/omcg_top.sv ====
`timescale 1ns/1ps
`include "omcg_cfg.svh"
// How it works
// - System clock from fast or substitute source.
// - Fast clock source always crystal: strap_q caught as zero.
// - Substitute source always slow crystal: strap_q caught as zero.
// - Normal mode divides fast clock 1 to 64.
// - Substitute and time-base sources always slow crystal.
// - Substitute clock bridges CPU after fast wake-up.
// - Switching to substitute stops fast oscillator.
// - Six modes gate CPU and clocks per table.
// - Slow mode runs low-speed, fast clock off.
// - Halt with idle disabled enters a sleep.
// - Deep sleep stops all, disables watchdog.
// - Voltage detect enabled blocks deep sleep.
// - Light sleep keeps substitute and fS running.
// - Halt, idle on, keep off: idle stopped.
// - Idle stopped state halts system oscillator.
// - Halt, idle and keep on: idle running.
// - Idle running keeps system oscillator going.
// - Divider field codes substitute or fast/64..2.
// - Select bit high picks undivided fast clock.
module omcg_top (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [3:0]           osc_pin,
  input  wire omcg_pkg::omcg_strap_t strap_pin,
  input  wire omcg_pkg::omcg_ctrl_t  ctrl,
  input  wire logic                 halt_req,
  input  wire logic                 wake_req,
  input  wire logic                 wdt_enable,
  input  wire logic                 wdt_on_sub,
  output logic                      system_clock,
  output logic                      high_freq_clock,
  output logic                      substitute_clock,
  output logic                      secondary_periph_clock,
  output logic                      time_base_clock,
  output logic                      cpu_run,
  output logic [1:0]                fast_osc_on,
  output logic [1:0]                slow_osc_on,
  output logic                      wdt_disable,
  output omcg_pkg::omcg_mode_t      mode_q
);

  //////////////////////////////////////////////////////////////////////////////
  logic [3:0]            osc_s1_q;
  logic [3:0]            osc_s2_q;
  logic [3:0]            osc_s3_q;
  logic [2:0]            strap_s1_q;
  logic [2:0]            strap_s2_q;
  logic [1:0]            strap_cnt_q;
  omcg_pkg::omcg_strap_t strap_q;
  logic [5:0]            div_q;
  omcg_pkg::omcg_sel_t   sel_q;
  logic                  warm_q;
  logic [7:0]            warm_cnt_q;
  omcg_pkg::omcg_mode_t  mode_d;

  // Oscillator pins cross into clk through two flops, then edge detect
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      osc_s1_q <= 4'h0;
      osc_s2_q <= 4'h0;
      osc_s3_q <= 4'h0;
    end
    else
    begin
      osc_s1_q <= osc_pin;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  // Straps synchronised; strap_q loaded once, from strap_s2_q while it still holds reset zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      strap_s1_q  <= 3'h0;
      strap_s2_q  <= 3'h0;
      strap_cnt_q <= 2'h0;
      strap_q     <= 3'h0;
    end
    else
    begin
      strap_s1_q <= strap_pin;
      strap_s2_q <= strap_s1_q;
      if (strap_cnt_q != `OMCG_STRAP_WAIT)
        strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == `OMCG_STRAP_WAIT - 2'h1)
        strap_q <= strap_s2_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  wire [3:0] osc_edge  = osc_s2_q & ~osc_s3_q;
  wire       run_now   = (mode_q == omcg_pkg::omcg_normal) || (mode_q == omcg_pkg::omcg_slow);
  wire       sub_run   = mode_q != omcg_pkg::deep_halt_state;
  wire       tbc_run   = run_now || (mode_q == omcg_pkg::idle_clock_stopped_state)
                         || (mode_q == omcg_pkg::idle_clock_running_state);

  // Source ticks: fast gated by its oscillator enable, substitute and time base by mode
  wire hf_raw   = strap_q.hf_from_rc ? osc_edge[`OMCG_FAST_RC] : osc_edge[`OMCG_FAST_XT];
  wire hf_tick  = hf_raw & (|fast_osc_on);
  wire sub_raw  = strap_q.sub_from_rc ? osc_edge[`OMCG_SLOW_RC] : osc_edge[`OMCG_SLOW_XT];
  wire sub_tick = sub_raw & sub_run;
  wire tbc_raw  = strap_q.tbc_from_rc ? osc_edge[`OMCG_SLOW_RC] : osc_edge[`OMCG_SLOW_XT];
  wire tbc_tick = tbc_raw & tbc_run;

  // Divided fast tick for the active selection
  wire [2:0] div_sh   = sel_q.div - `OMCG_DIV_BASE;
  wire [5:0] div_mask = `OMCG_DIV_MASK >> div_sh;
  wire       div_tick = hf_tick & ((div_q & div_mask) == div_mask);
  wire       sel_sub  = !sel_q.hl && (sel_q.div <= `OMCG_DIV_SUB_MAX);
  wire       sel_tick = sel_q.hl ? hf_tick : (sel_sub ? sub_tick : div_tick);

  // Wanted selection from the control bits
  wire [3:0] sel_want = {ctrl.high_low_clock_select, ctrl.sysclk_divider_select};
  wire       src_dead = sel_sub ? !sub_run : !(|fast_osc_on);
  wire       sel_take = (sel_want != sel_q) && (sel_tick || src_dead);

  // Halt decisions from the bits present at the halt request
  wire keep_sub  = ctrl.low_voltage_detect_enable || (wdt_enable && wdt_on_sub);
  wire to_sleep  = run_now && halt_req && !ctrl.halt_to_idle_enable;
  wire to_idle   = run_now && halt_req && ctrl.halt_to_idle_enable;
  wire run_mode_sub = sel_sub;
  wire fast_wake = ctrl.fast_wakeup_enable && !strap_q.hf_from_rc && !sel_sub
                   && ((mode_q == omcg_pkg::light_halt_state)
                   || (mode_q == omcg_pkg::idle_clock_stopped_state));

  // Mode transitions
  always_comb
  begin
    mode_d = mode_q;
    unique case (mode_q)
      omcg_pkg::omcg_normal,
      omcg_pkg::omcg_slow:
      begin
        if (to_idle)
          mode_d = ctrl.idle_sysclk_keep_on ? omcg_pkg::idle_clock_running_state
                                            : omcg_pkg::idle_clock_stopped_state;
        else if (to_sleep)
          mode_d = keep_sub ? omcg_pkg::light_halt_state
                            : omcg_pkg::deep_halt_state;
        else
          mode_d = run_mode_sub ? omcg_pkg::omcg_slow : omcg_pkg::omcg_normal;
      end
      omcg_pkg::idle_clock_stopped_state,
      omcg_pkg::idle_clock_running_state,
      omcg_pkg::deep_halt_state,
      omcg_pkg::light_halt_state:
      begin
        if (wake_req)
          mode_d = run_mode_sub ? omcg_pkg::omcg_slow : omcg_pkg::omcg_normal;
      end
      default:
        mode_d = omcg_pkg::omcg_normal;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  wire idle_run  = mode_d == omcg_pkg::idle_clock_running_state;
  wire run_next  = (mode_d == omcg_pkg::omcg_normal) || (mode_d == omcg_pkg::omcg_slow);
  wire fast_need = (run_next || idle_run) && !sel_sub;
  wire sub_need  = mode_d != omcg_pkg::deep_halt_state;
  wire tbc_need  = run_next || idle_run || (mode_d == omcg_pkg::idle_clock_stopped_state);
  wire sys_tick  = run_now ? (warm_q ? sub_tick : sel_tick)
                 : ((mode_q == omcg_pkg::idle_clock_running_state) & sel_tick);
  wire warm_done = warm_q && hf_tick && (warm_cnt_q == `OMCG_WARM_LAST);

  // Mode, selection, divider and fast wake-up bridge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode_q     <= omcg_pkg::omcg_normal;
      sel_q      <= `OMCG_SEL_RESET;
      div_q      <= 6'h00;
      warm_q     <= 1'b0;
      warm_cnt_q <= 8'h00;
    end
    else
    begin
      mode_q <= mode_d;
      if (sel_take)
        sel_q <= sel_want;
      if (hf_tick)
        div_q <= div_q + 6'h01;
      if (!run_now && wake_req && fast_wake)
        warm_q <= 1'b1;
      else if (warm_done || !run_now)
        warm_q <= 1'b0;
      if (!warm_q)
        warm_cnt_q <= 8'h00;
      else if (hf_tick)
        warm_cnt_q <= warm_cnt_q + 8'h01;
    end
  end

  // Registered clock enables and oscillator controls
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      system_clock           <= 1'b0;
      high_freq_clock        <= 1'b0;
      substitute_clock       <= 1'b0;
      secondary_periph_clock <= 1'b0;
      time_base_clock        <= 1'b0;
      cpu_run                <= 1'b1;
      fast_osc_on            <= 2'h0;
      slow_osc_on            <= 2'h0;
      wdt_disable            <= 1'b0;
    end
    else
    begin
      system_clock           <= sys_tick;
      high_freq_clock        <= hf_tick;
      substitute_clock       <= sub_tick;
      secondary_periph_clock <= sub_tick;
      time_base_clock        <= tbc_tick;
      cpu_run                <= run_next;
      fast_osc_on            <= {fast_need && strap_q.hf_from_rc,
                                 fast_need && !strap_q.hf_from_rc};
      slow_osc_on            <= {(sub_need && strap_q.sub_from_rc) || (tbc_need && strap_q.tbc_from_rc),
                                 (sub_need && !strap_q.sub_from_rc) || (tbc_need && !strap_q.tbc_from_rc)};
      wdt_disable            <= mode_d == omcg_pkg::deep_halt_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_halt_deep;
    run_now && halt_req && !ctrl.halt_to_idle_enable && !keep_sub;
  endsequence

  sequence s_deep_held;
    (mode_q == omcg_pkg::deep_halt_state) ##1 (mode_q == omcg_pkg::deep_halt_state);
  endsequence

  a_deep_entry: assert property (s_halt_deep |=> s_deep_held or (mode_q == omcg_pkg::deep_halt_state))
    else $error("deep sleep not entered");
  a_deep_gates: assert property (s_deep_held |-> !substitute_clock && !secondary_periph_clock && wdt_disable)
    else $error("clocks alive in deep sleep");
  a_lvd_blocks: assert property (run_now && halt_req && !ctrl.halt_to_idle_enable && ctrl.low_voltage_detect_enable |=> mode_q == omcg_pkg::light_halt_state)
    else $error("deep sleep entered with voltage detect on");
  a_idle_pick: assert property (to_idle |=> mode_q == ($past(ctrl.idle_sysclk_keep_on) ? omcg_pkg::idle_clock_running_state : omcg_pkg::idle_clock_stopped_state))
    else $error("wrong idle state");
  a_idle_clock_stopped_state_stop: assert property ((mode_q == omcg_pkg::idle_clock_stopped_state) [*2] |-> fast_osc_on == 2'h0 && !system_clock)
    else $error("system oscillator runs in idle stopped");
  a_idle_clock_running_state_runs: assert property ((mode_q == omcg_pkg::idle_clock_running_state) && sel_tick |=> system_clock)
    else $error("system clock lost in idle running");
  a_slow_fastoff: assert property ((mode_q == omcg_pkg::omcg_slow) [*2] |-> fast_osc_on == 2'h0 && !high_freq_clock)
    else $error("fast clock on in slow mode");
  a_cpu_halted: assert property (!run_now [*2] |-> !cpu_run)
    else $error("cpu running while halted");
  a_clean_switch: assert property ($changed(sel_q) |-> $past(sel_tick || src_dead))
    else $error("selection changed mid period");
  a_div_ratio: assert property (system_clock && $past(!sel_q.hl && sel_q.div == 3'h7)
    && $past(run_now && !warm_q) |-> high_freq_clock && !div_q[0])
    else $error("divide by two misaligned");
  a_warm_bound: assert property (warm_q |-> warm_cnt_q <= `OMCG_WARM_LAST)
    else $error("fast wake bridge overran");

endmodule : omcg_top

// ==== dv/omcg_osc_model.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Oscillator bank: square waves, each held low while its enable is off
module omcg_osc_model (
  input  wire logic [1:0] fast_osc_on,
  input  wire logic [1:0] slow_osc_on,
  input  wire logic       clk,
  input  wire logic       rst,
  output logic      [3:0] osc_pin
);
  // Half periods in clk cycles: fast crystal, fast RC, slow crystal, slow RC
  localparam int HALF [4] = '{3, 4, 10, 12};

  logic [3:0] en_w;

  // Enable map, bit order matches pin order
  assign en_w = {slow_osc_on, fast_osc_on};

  for (genvar g = 0; g < 4; g++)
  begin : g_osc
    int cnt_q;
    // Stopped oscillator stands low, no stale toggling
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        cnt_q      <= 0;
        osc_pin[g] <= 1'b0;
      end
      else if (!en_w[g])
      begin
        cnt_q      <= 0;
        osc_pin[g] <= 1'b0;
      end
      else if (cnt_q == HALF[g] - 1)
      begin
        cnt_q      <= 0;
        osc_pin[g] <= ~osc_pin[g];
      end
      else
      begin
        cnt_q <= cnt_q + 1;
      end
    end
  end
endmodule : omcg_osc_model

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module testbench;
  logic                  clk, rst, halt_req, wake_req, wdt_enable, wdt_on_sub;
  logic [3:0]            osc_pin;
  omcg_pkg::omcg_strap_t strap_pin;
  omcg_pkg::omcg_ctrl_t  ctrl;
  logic                  system_clock, high_freq_clock, substitute_clock;
  logic                  secondary_periph_clock, time_base_clock, cpu_run, wdt_disable;
  logic [1:0]            fast_osc_on, slow_osc_on;
  omcg_pkg::omcg_mode_t  mode_q;
  int                    mismatches, check_count, seed;
  int                    sys_cnt, hf_cnt, sub_cnt, fs_cnt, tbc_cnt;

  omcg_top i_dut (.clk(clk), .rst(rst), .osc_pin(osc_pin), .strap_pin(strap_pin),
    .ctrl(ctrl), .halt_req(halt_req), .wake_req(wake_req), .wdt_enable(wdt_enable),
    .wdt_on_sub(wdt_on_sub), .system_clock(system_clock), .high_freq_clock(high_freq_clock),
    .substitute_clock(substitute_clock), .secondary_periph_clock(secondary_periph_clock),
    .time_base_clock(time_base_clock), .cpu_run(cpu_run), .fast_osc_on(fast_osc_on),
    .slow_osc_on(slow_osc_on), .wdt_disable(wdt_disable), .mode_q(mode_q));

  omcg_osc_model i_osc (.fast_osc_on(fast_osc_on), .slow_osc_on(slow_osc_on), .clk(clk),
    .rst(rst), .osc_pin(osc_pin));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and pulse counters
  initial clk = 1'b0;
  always #10 clk = ~clk;

  always @(posedge clk)
  begin
    if (system_clock === 1'b1) sys_cnt++;
    if (high_freq_clock === 1'b1) hf_cnt++;
    if (substitute_clock === 1'b1) sub_cnt++;
    if (secondary_periph_clock === 1'b1) fs_cnt++;
    if (time_base_clock === 1'b1) tbc_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    if (mismatches == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task automatic clr_counts;
    sys_cnt = 0;
    hf_cnt  = 0;
    sub_cnt = 0;
    fs_cnt  = 0;
    tbc_cnt = 0;
  endtask : clr_counts

  // Bounded wait for n system clock pulses
  task automatic wait_sys(input int n);
    int t;
    t = 0;
    clr_counts();
    while (sys_cnt < n && t < 4000)
    begin
      @(negedge clk);
      t++;
    end
    if (t >= 4000)
    begin
      mismatches++;
      stop_test();
    end
  endtask : wait_sys

  task automatic pulse(input bit is_halt);
    @(negedge clk);
    if (is_halt) halt_req = 1'b1;
    else wake_req = 1'b1;
    @(negedge clk);
    halt_req = 1'b0;
    wake_req = 1'b0;
  endtask : pulse

  // Low-power state expected from idle, keep, detect, watchdog-on-sub
  function automatic omcg_pkg::omcg_mode_t exp_mode(input logic [3:0] b, input logic wen);
    if (b[3] && b[2]) return omcg_pkg::idle_clock_running_state;
    if (b[3]) return omcg_pkg::idle_clock_stopped_state;
    if (b[1] || (wen && b[0])) return omcg_pkg::light_halt_state;
    return omcg_pkg::deep_halt_state;
  endfunction : exp_mode

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge clk);
    mismatches++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    omcg_pkg::omcg_mode_t em;
    int                   ratio, ok;
    logic [3:0]           b;
    logic                 warm;
    seed = 32'h7032;
    mismatches = 0;
    check_count = 0;
    rst = 1'b1;
    halt_req = 1'b0;
    wake_req = 1'b0;
    wdt_enable = 1'b0;
    wdt_on_sub = 1'b0;
    ctrl = 8'h80;
    strap_pin = 3'($random(seed));
    clr_counts();
    repeat (4) @(negedge clk);
    check(cpu_run, 1'b1);
    check(mode_q, omcg_pkg::omcg_normal);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    // Every divider code plus the undivided select: divided ratio or substitute clock
    for (int c = 8; c >= 0; c--)
    begin
      ctrl.high_low_clock_select = (c == 8);
      ctrl.sysclk_divider_select = 3'(c);
      wait_sys(2);
      repeat (20) @(negedge clk);
      clr_counts();
      repeat (1920) @(negedge clk);
      if (c >= 2)
      begin
        ratio = (c == 8) ? 1 : (1 << (8 - c));
        ok = (sys_cnt * ratio <= hf_cnt + ratio) && (sys_cnt * ratio + ratio >= hf_cnt);
        check(ok, 1);
      end
      else
      begin
        ok = (sys_cnt <= sub_cnt + 1) && (sys_cnt + 1 >= sub_cnt);
        check(ok, 1);
        check(hf_cnt, 0);
        check(fast_osc_on, 2'h0);
      end
    end
    ctrl = 8'h80;
    wait_sys(2);
    // Every halt combination, bits disturbed after the request
    for (int i = 0; i < 16; i++)
    begin
      b = 4'(i);
      {ctrl.halt_to_idle_enable, ctrl.idle_sysclk_keep_on} = b[3:2];
      ctrl.low_voltage_detect_enable = b[1];
      wdt_on_sub = b[0];
      wdt_enable = 1'($random(seed));
      ctrl.fast_wakeup_enable = 1'($random(seed));
      em = exp_mode(b, wdt_enable);
      pulse(1'b1);
      ctrl[3:1] = 3'($random(seed));
      check(mode_q, em);
      @(negedge clk);
      check(cpu_run, 1'b0);
      check(wdt_disable, em == omcg_pkg::deep_halt_state);
      pulse(1'b1);
      check(mode_q, em);
      repeat (10) @(negedge clk);
      clr_counts();
      repeat (96) @(negedge clk);
      check(sub_cnt != 0, em != omcg_pkg::deep_halt_state);
      check(fs_cnt, sub_cnt);
      check(tbc_cnt != 0, em > omcg_pkg::idle_clock_running_state ? 0 : 1);
      check(sys_cnt != 0, em == omcg_pkg::idle_clock_running_state);
      check(hf_cnt != 0, em == omcg_pkg::idle_clock_running_state);
      pulse(1'b0);
      check(mode_q, omcg_pkg::omcg_normal);
      @(negedge clk);
      check(cpu_run, 1'b1);
      // Fast wake bridge: system clock follows substitute ticks, else fast ticks
      warm = ctrl.fast_wakeup_enable && !strap_pin.hf_from_rc
             && (em == omcg_pkg::light_halt_state || em == omcg_pkg::idle_clock_stopped_state);
      clr_counts();
      repeat (200) @(negedge clk);
      check(sys_cnt, warm ? sub_cnt : hf_cnt);
      wait_sys(2);
      pulse(1'b0);
      check(mode_q, omcg_pkg::omcg_normal);
    end
    stop_test();
  end
endmodule : testbench
